// ---- shared/ptbi_pkg.sv ----
// Package for the periodic timebase: register map, field layout,
// reset values and the rate table of the divider chain.
// Assumes a 32-bit APB slave and a crystal tick sampled in the core clock.

package ptbi_pkg;

   // ----------------------------------------------------------------
   // Divider chain
   // ----------------------------------------------------------------
   // The rate table below only gives the printed rates with this crystal.
   localparam int unsigned PTBI_XTAL_HZ   = 32768;
   localparam int unsigned PTBI_STAGES    = 15;
   localparam int unsigned PTBI_RATE_W    = 3;
   localparam int unsigned PTBI_TAP_W     = 4;

   // Tap bit per rate code: the tap rises first after half of the
   // division ratio and then once per full ratio.
   localparam logic [3:0] PTBI_TAP_DIV32768 = 4'he;
   localparam logic [3:0] PTBI_TAP_DIV8192  = 4'hc;
   localparam logic [3:0] PTBI_TAP_DIV2048  = 4'ha;
   localparam logic [3:0] PTBI_TAP_DIV128   = 4'h6;
   localparam logic [3:0] PTBI_TAP_DIV64    = 4'h5;
   localparam logic [3:0] PTBI_TAP_DIV32    = 4'h4;
   localparam logic [3:0] PTBI_TAP_DIV16    = 4'h3;
   localparam logic [3:0] PTBI_TAP_DIV8     = 4'h2;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int unsigned PTBI_ADDR_W         = 8;
   localparam logic [7:0]  PTBI_OFS_CONTROL    = 8'h00;
   localparam logic [7:0]  PTBI_OFS_COUNT      = 8'h04;

   // Fields of timebase_control.
   localparam int unsigned PTBI_BIT_PENDING    = 7;
   localparam int unsigned PTBI_BIT_RATE_HI    = 6;
   localparam int unsigned PTBI_BIT_RATE_LO    = 4;
   localparam int unsigned PTBI_BIT_ACK        = 3;
   localparam int unsigned PTBI_BIT_IRQ_EN     = 2;
   localparam int unsigned PTBI_BIT_ENABLE     = 1;

   // Reset values.
   localparam logic [2:0]  PTBI_RST_RATE       = 3'h0;
   localparam logic        PTBI_RST_IRQ_EN     = 1'h0;
   localparam logic        PTBI_RST_ENABLE     = 1'h0;

   function automatic logic [3:0] ptbi_tap_of(input logic [2:0] code);
      logic [3:0] tap;
      tap = PTBI_TAP_DIV32768;
      case (code)
         3'h0:    tap = PTBI_TAP_DIV32768;
         3'h1:    tap = PTBI_TAP_DIV8192;
         3'h2:    tap = PTBI_TAP_DIV2048;
         3'h3:    tap = PTBI_TAP_DIV128;
         3'h4:    tap = PTBI_TAP_DIV64;
         3'h5:    tap = PTBI_TAP_DIV32;
         3'h6:    tap = PTBI_TAP_DIV16;
         default: tap = PTBI_TAP_DIV8;
      endcase
      return tap;
   endfunction : ptbi_tap_of

endpackage : ptbi_pkg

// ---- hw/ptbi_divider.sv ----
// Divider counter chain of the periodic timebase with its tap selector.
// Assumes the crystal tick is a one-cycle pulse in the core clock domain.

`timescale 1ns/1ns
`default_nettype none

module ptbi_divider #(
   parameter int unsigned STAGES = ptbi_pkg::PTBI_STAGES,
   parameter int unsigned TAP_W  = ptbi_pkg::PTBI_TAP_W
) (
   input  wire logic              core_clk_i,
   input  wire logic              rst_i,
   input  wire logic              enable_i,
   input  wire logic              advance_i,
   input  wire logic [TAP_W-1:0]  tap_i,
   output logic                   rollover_o,
   output logic [STAGES-1:0]      count_o
);

   // ----------------------------------------------------------------
   // Counter
   // ----------------------------------------------------------------
   logic [STAGES-1:0] count_q;
   logic [STAGES-1:0] count_d;
   logic              rollover_q;
   logic              rollover_d;

   always_comb begin
      count_d    = count_q;
      rollover_d = 1'b0;
      if (!enable_i) begin
         count_d = '0;
      end else if (advance_i) begin
         count_d    = count_q + {{(STAGES-1){1'b0}}, 1'b1};
         // A rising tap bit is the rollover of the selected stage.
         rollover_d = count_d[tap_i] & ~count_q[tap_i];
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         count_q    <= '0;
         rollover_q <= 1'b0;
      end else begin
         count_q    <= count_d;
         rollover_q <= rollover_d;
      end
   end

   assign rollover_o = rollover_q;
   assign count_o    = count_q;

endmodule : ptbi_divider

`default_nettype wire

// ---- hw/ptbi_top.sv ----
// Periodic timebase interrupt generator with an APB register port.
// Assumes the crystal clock arrives as a plain input synchronous to the
// core clock, and that wait and stop mode indications come from the
// power controller of the chip.
//
// Local design decisions: the APB interface to the registers and the address map.

`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - Disabled module holds counter at zero.
// - Enabled module counts crystal clock edges.
// - Selected tap rollover sets pending flag.
// - Pending and irq enable raise interrupt.
// - First event half period, then full.
// - Rate codes pick ratios 32768 down to 8.
// - Acknowledge bit always reads zero.
// - Writing one acknowledges; zero does nothing.
// - Pending flag read-only, set by rollover.
// - Irq enable readable, writable, reset clear.
// - Module enable readable, writable, reset clear.
// - Wait mode counts; register access blocked.
// - Stop with oscillator running counts, wakes.
// - Stop without oscillator: idle, inaccessible.
// - Rate table assumes 32.768 kHz crystal.
// - Fifteen stages, eight selectable taps.
module ptbi_top #(
   parameter int unsigned ADDR_W = ptbi_pkg::PTBI_ADDR_W,
   parameter int unsigned STAGES = ptbi_pkg::PTBI_STAGES
) (
   input  wire logic              core_clk_i,
   input  wire logic              rst_i,
   input  wire logic              psel_i,
   input  wire logic              penable_i,
   input  wire logic              pwrite_i,
   input  wire logic [ADDR_W-1:0] paddr_i,
   input  wire logic [31:0]       pwdata_i,
   input  wire logic [3:0]        pstrb_i,
   output logic      [31:0]       prdata_o,
   output logic                   pready_o,
   output logic                   pslverr_o,
   input  wire logic              divider_input_clock_i,
   input  wire logic              wait_mode_i,
   input  wire logic              stop_mode_i,
   input  wire logic              oscillator_run_in_stop_i,
   output logic                   irq_o,
   output logic                   wakeup_o
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic              xtal_prev_q;
   logic              xtal_prev_d;
   logic              xtal_tick;
   logic              osc_alive;
   logic              advance;

   logic [2:0]        rate_select_field_q;
   logic [2:0]        rate_select_field_d;
   logic              rollover_irq_enable_q;
   logic              rollover_irq_enable_d;
   logic              module_enable_bit_q;
   logic              module_enable_bit_d;
   logic              rollover_pending_flag_q;
   logic              rollover_pending_flag_d;

   logic              irq_q;
   logic              irq_d;
   logic              wakeup_q;
   logic              wakeup_d;

   logic [31:0]       prdata_q;
   logic [31:0]       prdata_d;
   logic              pready_q;
   logic              pready_d;
   logic              pslverr_q;
   logic              pslverr_d;

   logic              setup_phase;
   logic              access_done;
   logic              bus_blocked;
   logic              hit_control;
   logic              hit_count;
   logic              wr_control;
   logic              flag_acknowledge_bit;
   logic              rollover;
   logic [STAGES-1:0] count;
   logic [7:0]        control_view;
   logic [3:0]        tap_select_q;
   logic [3:0]        tap_select_d;
   logic [31:0]       count_view;

   // ----------------------------------------------------------------
   // Crystal tick and low-power gating
   // ----------------------------------------------------------------
   // The crystal clock is far slower than the core clock, so a rising
   // edge seen in two successive samples is one crystal period.
   always_comb begin
      xtal_prev_d = divider_input_clock_i;
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         xtal_prev_q <= 1'b0;
      end else begin
         xtal_prev_q <= xtal_prev_d;
      end
   end

   assign xtal_tick = divider_input_clock_i & ~xtal_prev_q;

   // Wait mode leaves the oscillator running; stop mode keeps it only
   // when it has been allowed to run there.
   assign osc_alive = ~stop_mode_i | oscillator_run_in_stop_i;
   assign advance   = xtal_tick & osc_alive;

   // ----------------------------------------------------------------
   // Tap selection
   // ----------------------------------------------------------------
   // The tap is registered to keep the rate decode off the compare path.
   // A rate write reaches the chain one cycle late, which is harmless
   // because software keeps the rate fixed while the chain counts.
   always_comb begin
      tap_select_d = ptbi_pkg::ptbi_tap_of(rate_select_field_q);
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         tap_select_q <= ptbi_pkg::PTBI_TAP_DIV32768;
      end else begin
         tap_select_q <= tap_select_d;
      end
   end

   // ----------------------------------------------------------------
   // Count view
   // ----------------------------------------------------------------
   // The chain is one register, so a read never sees a torn value.
   always_comb begin
      count_view             = 32'h0000_0000;
      count_view[STAGES-1:0] = count;
   end

   // ----------------------------------------------------------------
   // Divider chain
   // ----------------------------------------------------------------
   // Clearing the enable zeroes the chain, so a clear and set restarts
   // the period from the beginning.
   ptbi_divider #(
      .STAGES (STAGES),
      .TAP_W  (ptbi_pkg::PTBI_TAP_W)
   ) u_divider (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .enable_i   (module_enable_bit_q),
      .advance_i  (advance),
      .tap_i      (tap_select_q),
      .rollover_o (rollover),
      .count_o    (count)
   );

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   // The CPU cannot reach the register in either low-power mode; an
   // access then is answered with an error and has no effect.
   assign bus_blocked = wait_mode_i | stop_mode_i;
   assign setup_phase = psel_i & ~penable_i;
   assign access_done = psel_i & penable_i & pready_q;
   assign hit_control = (paddr_i == ptbi_pkg::PTBI_OFS_CONTROL);
   assign hit_count   = (paddr_i == ptbi_pkg::PTBI_OFS_COUNT);
   assign wr_control  = access_done & pwrite_i & hit_control & pstrb_i[0]
                        & ~pslverr_q;

   assign flag_acknowledge_bit = wr_control & pwdata_i[ptbi_pkg::PTBI_BIT_ACK];

   // The acknowledge position always reads back as zero.
   always_comb begin
      control_view = 8'h00;
      control_view[ptbi_pkg::PTBI_BIT_PENDING] = rollover_pending_flag_q;
      control_view[ptbi_pkg::PTBI_BIT_RATE_HI:ptbi_pkg::PTBI_BIT_RATE_LO] =
         rate_select_field_q;
      control_view[ptbi_pkg::PTBI_BIT_IRQ_EN]  = rollover_irq_enable_q;
      control_view[ptbi_pkg::PTBI_BIT_ENABLE]  = module_enable_bit_q;
   end

   // ----------------------------------------------------------------
   // APB answer
   // ----------------------------------------------------------------
   // The answer is prepared in the setup cycle, so every transfer ends
   // at the first access edge with no wait state.
   always_comb begin
      prdata_d  = prdata_q;
      pready_d  = 1'b0;
      pslverr_d = 1'b0;
      if (setup_phase) begin
         pready_d  = 1'b1;
         prdata_d  = 32'h0000_0000;
         pslverr_d = bus_blocked | ~(hit_control | hit_count)
                     | (pwrite_i & hit_count);
         if (!pwrite_i && !bus_blocked) begin
            if (hit_control) begin
               prdata_d = {24'h00_0000, control_view};
            end else if (hit_count) begin
               prdata_d = count_view;
            end
         end
      end else if (psel_i && penable_i && !pready_q) begin
         pready_d  = 1'b1;
         pslverr_d = pslverr_q;
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         prdata_q  <= 32'h0000_0000;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         prdata_q  <= prdata_d;
         pready_q  <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   // ----------------------------------------------------------------
   // Control fields
   // ----------------------------------------------------------------
   // A rate change while enabled is accepted as written; software is
   // expected to disable first, otherwise one period may be cut short.
   always_comb begin
      rate_select_field_d   = rate_select_field_q;
      rollover_irq_enable_d = rollover_irq_enable_q;
      module_enable_bit_d   = module_enable_bit_q;
      if (wr_control) begin
         rate_select_field_d   = pwdata_i[ptbi_pkg::PTBI_BIT_RATE_HI:
                                          ptbi_pkg::PTBI_BIT_RATE_LO];
         rollover_irq_enable_d = pwdata_i[ptbi_pkg::PTBI_BIT_IRQ_EN];
         module_enable_bit_d   = pwdata_i[ptbi_pkg::PTBI_BIT_ENABLE];
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rate_select_field_q   <= ptbi_pkg::PTBI_RST_RATE;
         rollover_irq_enable_q <= ptbi_pkg::PTBI_RST_IRQ_EN;
         module_enable_bit_q   <= ptbi_pkg::PTBI_RST_ENABLE;
      end else begin
         rate_select_field_q   <= rate_select_field_d;
         rollover_irq_enable_q <= rollover_irq_enable_d;
         module_enable_bit_q   <= module_enable_bit_d;
      end
   end

   // ----------------------------------------------------------------
   // Pending flag
   // ----------------------------------------------------------------
   // Only a rollover sets the flag and only a written one clears it; a
   // rollover in the same cycle as the clear wins so no event is lost.
   always_comb begin
      rollover_pending_flag_d = rollover_pending_flag_q;
      if (flag_acknowledge_bit) begin
         rollover_pending_flag_d = 1'b0;
      end
      if (rollover) begin
         rollover_pending_flag_d = 1'b1;
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rollover_pending_flag_q <= 1'b0;
      end else begin
         rollover_pending_flag_q <= rollover_pending_flag_d;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt and wakeup
   // ----------------------------------------------------------------
   // Both outputs follow the flag and enable of the same cycle, so the
   // request drops on the edge where the acknowledge takes effect.
   always_comb begin
      irq_d    = rollover_pending_flag_d & rollover_irq_enable_d;
      wakeup_d = irq_d & stop_mode_i & oscillator_run_in_stop_i;
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_q    <= 1'b0;
         wakeup_q <= 1'b0;
      end else begin
         irq_q    <= irq_d;
         wakeup_q <= wakeup_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign prdata_o  = prdata_q;
   assign pready_o  = pready_q;
   assign pslverr_o = pslverr_q;
   assign irq_o     = irq_q;
   assign wakeup_o  = wakeup_q;

endmodule : ptbi_top

`default_nettype wire

// ---- test/ptbi_monitor.sv ----
// Checker for the periodic timebase: bus answers, refusals, irq gating.
// Assumes it is bound to ptbi_top and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
module ptbi_monitor #(
   parameter int unsigned ADDR_W = 8
) (
   input wire logic              core_clk_i,
   input wire logic              rst_i,
   input wire logic              psel_i,
   input wire logic              penable_i,
   input wire logic              pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [31:0]       pwdata_i,
   input wire logic [3:0]        pstrb_i,
   input wire logic [31:0]       prdata_o,
   input wire logic              pready_o,
   input wire logic              pslverr_o,
   input wire logic              wait_mode_i,
   input wire logic              stop_mode_i,
   input wire logic              oscillator_run_in_stop_i,
   input wire logic              irq_o,
   input wire logic              wakeup_o
);
   logic en_q, en_d, ie_q, ie_d, wr_ok, setup;
   // ----------------------------------------------------------------
   // Shadow of the enables, kept from accepted writes only.
   // ----------------------------------------------------------------
   always_comb begin
      setup = psel_i && !penable_i;
      wr_ok = psel_i && penable_i && pready_o && pwrite_i && !pslverr_o
              && paddr_i == '0 && pstrb_i[0];
      en_d = wr_ok ? pwdata_i[1] : en_q;
      ie_d = wr_ok ? pwdata_i[2] : ie_q;
   end
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         en_q <= 1'b0;
         ie_q <= 1'b0;
      end else begin
         en_q <= en_d;
         ie_q <= ie_d;
      end
   end
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   a_ready_one_cycle: assert property (setup |=> pready_o ##1 !pready_o)
      else $error("ready not a single cycle after setup");
   a_refuse_in_mode: assert property (
      setup && !pwrite_i && (wait_mode_i || stop_mode_i) |=> pslverr_o && prdata_o == 32'h0)
      else $error("access in low power mode not refused");
   a_refuse_bad_addr: assert property (setup && (paddr_i > 'h4 || paddr_i == 'h4 && pwrite_i)
      |=> pslverr_o) else $error("bad access not refused");
   a_ack_reads_zero: assert property (
      pready_o && !pwrite_i && paddr_i == '0 |-> prdata_o[3] == 1'b0 && prdata_o[0] == 1'b0)
      else $error("acknowledge bit read back as one");
   a_count_held_zero: assert property (
      pready_o && !pwrite_i && paddr_i == 'h4 && !en_q && !$past(en_q) && !$past(en_q, 2)
      |-> prdata_o[14:0] == 15'h0) else $error("counter not zero while disabled");
   a_irq_needs_enable: assert property (irq_o |-> ie_q)
      else $error("irq without irq enable");
   a_flag_only_rollover: assert property (
      !en_q && !$past(en_q) && !$past(en_q, 2) && !irq_o |=> !irq_o || $rose(ie_q))
      else $error("irq rose while disabled");
   a_wake_cause: assert property (
      wakeup_o |-> $past(stop_mode_i && oscillator_run_in_stop_i) && (irq_o || $past(irq_o)))
      else $error("wakeup without stop, oscillator and irq");
   c_irq: cover property ($rose(irq_o));
   c_wake: cover property (wakeup_o);
   c_err: cover property (pslverr_o);
   c_ack: cover property (wr_ok && pwdata_i[3]);
endmodule : ptbi_monitor
bind ptbi_top ptbi_monitor #(.ADDR_W(ADDR_W)) i_ptbi_monitor (
   .core_clk_i(core_clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
   .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .wait_mode_i(wait_mode_i), .stop_mode_i(stop_mode_i),
   .oscillator_run_in_stop_i(oscillator_run_in_stop_i), .irq_o(irq_o), .wakeup_o(wakeup_o));
`default_nettype wire

// ---- test/tb_ptbi_top.sv ----
// Self-checking bench for the periodic timebase over APB.
// Assumes the crystal is fast here: one tick every four core cycles.
`timescale 1ns/1ns
`default_nettype none
module tb_ptbi_top;
   logic        clk, rst, psel, pen, pwr, xtal, wt, stp, osc, rdy, err, irq, wk, er;
   logic [7:0]  addr;
   logic [3:0]  strb;
   logic [31:0] wdat, rdat, rd, v;
   int          fail_count, compares, ticks, ph, t0, d, n;
   int unsigned ratio [8] = '{32768, 8192, 2048, 128, 64, 32, 16, 8};
   ptbi_top i_ptbi_top (.core_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(pen),
      .pwrite_i(pwr), .paddr_i(addr), .pwdata_i(wdat), .pstrb_i(strb), .prdata_o(rdat),
      .pready_o(rdy), .pslverr_o(err), .divider_input_clock_i(xtal), .wait_mode_i(wt),
      .stop_mode_i(stp), .oscillator_run_in_stop_i(osc), .irq_o(irq), .wakeup_o(wk));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      ph <= ph + 1;
      if (ph[0]) begin
         xtal <= ~xtal;
         if (!xtal) ticks <= ticks + 1;
      end
   end
   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %0t %s", $time, m);
      end
   endtask : chk
   task apb(input logic w, input logic [7:0] a, input logic [31:0] dv);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      addr <= a;
      wdat <= dv;
      @(posedge clk);
      pen <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (rdy !== 1'b1);
      rd = rdat;
      er = err;
      chk(k, 1, "wait state");
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb
   task wirq(input int lim);
      n = 0;
      while (irq !== 1'b1 && n < lim) begin
         @(negedge clk);
         n++;
      end
      if (n >= lim) chk(0, 1, "irq wait");
   endtask : wirq
   function automatic logic [31:0] ctl(input logic [2:0] r, input logic ie, en, ak);
      return {24'h0, 1'b0, r, ak, ie, en, 1'b0};
   endfunction : ctl
   task summarize;
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : summarize
   initial begin
      #950000;
      fail_count++;
      $display("unexpected %0t watchdog", $time);
      summarize;
   end
   initial begin
      {psel, pen, pwr, xtal, wt, stp, osc, addr, wdat} = '0;
      {fail_count, compares, ticks, ph} = '0;
      strb = 4'hf;
      rst = 1'b1;
      v = $urandom(32'hdc1c);
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      apb(0, 8'h00, 0); chk(rd, 0, "control reset");
      apb(0, 8'h04, 0); chk(rd, 0, "count reset");
      apb(0, 8'h08, 0); chk(er, 1, "unmapped read");
      apb(1, 8'h04, 32'hff); chk(er, 1, "count write");
      $display("test reset done");
      repeat (8) begin
         v = $urandom & 32'hfd;
         apb(1, 8'h00, v);
         apb(0, 8'h00, 0); chk(rd, v & 32'h74, "readback");
      end
      strb <= 4'he;
      apb(1, 8'h00, 32'h74);
      strb <= 4'hf;
      apb(0, 8'h00, 0); chk(rd, v & 32'h74, "strobe off");
      $display("test readback done");
      for (int c = 7; c >= 1; c--) begin
         apb(1, 8'h00, ctl(c[2:0], 1, 0, 1));
         apb(1, 8'h00, ctl(c[2:0], 1, 1, 0));
         t0 = ticks;
         wirq(ratio[c] * 2 + 64);
         d = ticks - t0;
         chk(d >= ratio[c] / 2 - 1 && d <= ratio[c] / 2 + 1, 1, "first event");
         t0 = ticks;
         apb(0, 8'h00, 0); chk(rd, ctl(c[2:0], 1, 1, 0) | 32'h80, "flag");
         apb(1, 8'h00, ctl(c[2:0], 1, 1, 0));
         @(negedge clk); chk(irq, 1, "ack zero");
         apb(1, 8'h00, ctl(c[2:0], 1, 1, 1));
         @(negedge clk); chk(irq, 0, "ack one");
         wirq(ratio[c] * 4 + 64);
         chk(ticks - t0, ratio[c], "period");
         apb(1, 8'h00, ctl(c[2:0], 0, 0, 1));
         apb(0, 8'h04, 0); chk(rd, 0, "cleared");
         $display("test rate %0d done", c);
      end
      apb(1, 8'h00, ctl(7, 1, 1, 1));
      wt <= 1'b1;
      apb(0, 8'h00, 0); chk({er, rd[30:0]}, 32'h80000000, "wait access");
      wirq(200); chk(irq, 1, "wait counts");
      @(posedge clk);
      wt <= 1'b0;
      apb(1, 8'h00, ctl(7, 1, 0, 1));
      apb(1, 8'h00, ctl(7, 1, 1, 0));
      stp <= 1'b1;
      apb(1, 8'h00, 0); chk(er, 1, "stop access");
      repeat (100) begin
         @(negedge clk); chk({irq, wk}, 0, "stop idle");
      end
      @(posedge clk);
      osc <= 1'b1;
      wirq(200);
      @(negedge clk); chk(wk, 1, "wakeup");
      @(posedge clk);
      stp <= 1'b0;
      osc <= 1'b0;
      apb(1, 8'h00, ctl(7, 1, 0, 1));
      $display("test low power done");
      summarize;
   end
endmodule : tb_ptbi_top
`default_nettype wire
